// *** core/lapic_pkg.sv ***
// Purpose: Shared constants and types for the light ADC power and integration control link
// Assumes: 20 MHz system clock on both ends
// Notes: Register addresses are the device's own; APB offsets belong to the host controller
package lapic_pkg;

    // Link transaction kinds; special carries a function code in the address field
    typedef enum logic [1:0] {
        LAPIC_KIND_WRITE = 2'b00,
        LAPIC_KIND_READ = 2'b01,
        LAPIC_KIND_SPECIAL = 2'b11
    } lapic_kind_t;

    // Device register addresses
    localparam logic [4:0] CTRL_ADDR = 5'h00;
    localparam logic [4:0] TIMING_ADDR = 5'h01;

    // Control register field positions
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_EN_BIT = 1;
    localparam int CTRL_VALID_BIT = 4;
    localparam int CTRL_IRQ_BIT = 5;
    localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h03;
    localparam logic [7:0] CTRL_POWER_ONLY = 8'h01;

    // Reset values
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Special function codes
    localparam logic [4:0] FN_IRQ_CLEAR = 5'h01;
    localparam logic [4:0] FN_STOP = 5'h02;
    localparam logic [4:0] FN_START = 5'h03;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STEP_TIME_NS = 2700000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int POWER_WAIT_NS = 2000000;
    localparam int POWER_WAIT_CYCLES = (POWER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Host APB register offsets
    localparam logic [11:0] APB_CMD_OFS = 12'h000;
    localparam logic [11:0] APB_STATUS_OFS = 12'h004;
    localparam logic [11:0] APB_IRQ_STAT_OFS = 12'h008;
    localparam logic [11:0] APB_IRQ_MASK_OFS = 12'h00c;

    // Host command word fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_KIND_LSB = 13;

    // Host status word fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RDATA_LSB = 8;
    localparam int STAT_DEV_IRQ_BIT = 16;
    localparam int STAT_PWR_OK_BIT = 17;

    // Host interrupt status and mask bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_DEV_BIT = 1;
    localparam int IRQ_W = 2;

endpackage

// *** core/lapic_link_if.sv ***
// Purpose: Command link between the host controller and the light ADC device
// Assumes: Single clock shared by both ends
// Notes: Request is a level held until a one-cycle acknowledge
`timescale 1ns/10ps
`default_nettype none
interface lapic_link_if;
    logic req;
    lapic_pkg::lapic_kind_t kind;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic irq_n;

    modport host (output req, output kind, output addr, output wdata, input ack, input rdata, input irq_n);
    modport dev (input req, input kind, input addr, input wdata, output ack, output rdata, output irq_n);
endinterface
`default_nettype wire

// *** core/lapic_dev.sv ***
// Purpose: Light ADC device end: power, converter enable, integration timing and interrupt flag
// Assumes: Link inputs are synchronous to clock_i; the host keeps its own sequencing duties
// Notes: Channel data, threshold and persistence logic are not part of this block
//
// Summary of operation
// - Host writes zero to unused control bits
// - Control bit 5 mirrors active interrupt output
// - Control bit 4 set after integration completes
// - Control bit 1 starts or stops converters
// - Control bit 0 powers device on or off
// - Host sets power and enable before converting
// - Host waits 2 ms between power and enable
// - Host configures registers before enabling converters; the host controller forwards timing writes while converters are enabled
// - Integration counted in 2.7 ms steps
// - Timing register resets to zero, manual mode
// - Step total is 256 minus timing value
// - Timing value one gives 255 steps
// - Timing zero selects host-driven manual integration
// - Special codes 00011 start, 00010 stop manual
// - Special code 00001 clears pending interrupt
`timescale 1ns/10ps
`default_nettype none
module lapic_dev #(
    parameter int STEP_CYCLES = lapic_pkg::STEP_CYCLES
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    lapic_link_if.dev link,
    output logic powered_o,
    output logic converting_o,
    output logic conv_done_o,
    output logic [7:0] step_total_o
);

    logic power_reg;
    logic en_reg;
    logic [7:0] integration_step_count_reg;
    logic valid_reg;
    logic irq_pending_flag_reg;
    logic manual_run_reg;
    logic [lapic_pkg::CNT_W-1:0] div_reg;
    logic [7:0] steps_reg;
    logic ack_reg;
    logic [7:0] rdata_reg;
    logic irq_n_reg;
    logic powered_reg;
    logic converting_reg;
    logic conv_done_reg;
    logic [7:0] step_total_reg;

    logic valid_next;
    logic irq_next;
    logic manual_run_next;
    logic [lapic_pkg::CNT_W-1:0] div_next;
    logic [7:0] steps_next;

    // Request decode; a request is taken once, on the cycle before its acknowledge
    wire take = link.req & ~ack_reg;
    wire is_write = (link.kind == lapic_pkg::LAPIC_KIND_WRITE);
    wire is_read = (link.kind == lapic_pkg::LAPIC_KIND_READ);
    wire is_special = (link.kind == lapic_pkg::LAPIC_KIND_SPECIAL);
    wire hit_ctrl = (link.addr == lapic_pkg::CTRL_ADDR);
    wire hit_timing = (link.addr == lapic_pkg::TIMING_ADDR);
    wire wr_ctrl = take & is_write & hit_ctrl;
    wire wr_timing = take & is_write & hit_timing;
    wire rd = take & is_read;
    wire special = take & is_special;

    // Special functions
    wire clr_irq = special & (link.addr == lapic_pkg::FN_IRQ_CLEAR);
    wire manual_mode = (integration_step_count_reg == 8'h00);
    wire start_cmd = special & manual_mode & (link.addr == lapic_pkg::FN_START);
    wire stop_cmd = special & manual_mode & (link.addr == lapic_pkg::FN_STOP);

    // Run conditions
    wire enabled = power_reg & en_reg;
    wire timed_run = enabled & ~manual_mode;
    wire running = timed_run | (enabled & manual_run_reg);

    // Two's complement step total: 0xff gives 1 step, 0x01 gives 255
    wire [7:0] step_total = ~integration_step_count_reg + 8'h01;
    wire step_tick = running & (div_reg == lapic_pkg::CNT_W'(STEP_CYCLES - 1));
    // A shortened period ends at the next step tick, not after the counter wraps
    wire last_step = step_tick & timed_run & (steps_reg >= step_total - 8'h01);
    wire manual_end = stop_cmd & manual_run_reg & enabled;
    wire cycle_done = last_step | manual_end;

    // Register read view; reserved bits read as zero
    wire [7:0] ctrl_view = {2'b00, irq_pending_flag_reg, valid_reg, 2'b00, en_reg, power_reg};
    wire [7:0] read_mux = hit_ctrl ? ctrl_view : (hit_timing ? integration_step_count_reg : 8'h00);

    // Next-state logic for flags and counters
    always_comb
    begin
        // Completion sets the flag; it stays until the converters are disabled
        valid_next = cycle_done | (valid_reg & en_reg);
        // Set wins over a clear in the same cycle
        irq_next = cycle_done | (irq_pending_flag_reg & ~clr_irq);

        manual_run_next = manual_run_reg;
        if (!enabled || !manual_mode)
        begin
            manual_run_next = 1'b0;
        end
        else if (start_cmd)
        begin
            manual_run_next = 1'b1;
        end
        else if (stop_cmd)
        begin
            manual_run_next = 1'b0;
        end

        // Step divider restarts on every manual start
        div_next = div_reg;
        if (!running || start_cmd || step_tick)
        begin
            div_next = '0;
        end
        else
        begin
            div_next = div_reg + lapic_pkg::CNT_W'(1);
        end

        // Step counter wraps to the next integration at once
        steps_next = steps_reg;
        if (!timed_run || last_step)
        begin
            steps_next = 8'h00;
        end
        else if (step_tick)
        begin
            steps_next = steps_reg + 8'h01;
        end
    end

    // Control and timing registers
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            power_reg <= lapic_pkg::CTRL_RESET[lapic_pkg::CTRL_POWER_BIT];
            en_reg <= lapic_pkg::CTRL_RESET[lapic_pkg::CTRL_EN_BIT];
            integration_step_count_reg <= lapic_pkg::TIMING_RESET;
        end
        else
        begin
            if (wr_ctrl)
            begin
                power_reg <= link.wdata[lapic_pkg::CTRL_POWER_BIT];
                en_reg <= link.wdata[lapic_pkg::CTRL_EN_BIT];
            end
            if (wr_timing)
            begin
                integration_step_count_reg <= link.wdata;
            end
        end
    end

    // Integration state
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            valid_reg <= 1'b0;
            irq_pending_flag_reg <= 1'b0;
            manual_run_reg <= 1'b0;
            div_reg <= '0;
            steps_reg <= 8'h00;
        end
        else
        begin
            valid_reg <= valid_next;
            irq_pending_flag_reg <= irq_next;
            manual_run_reg <= manual_run_next;
            div_reg <= div_next;
            steps_reg <= steps_next;
        end
    end

    // Link answer and interrupt pin
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            irq_n_reg <= 1'b1;
        end
        else
        begin
            ack_reg <= take;
            if (rd)
            begin
                rdata_reg <= read_mux;
            end
            // Pin and status bit change on the same edge, so they always agree
            irq_n_reg <= ~irq_next;
        end
    end

    // User-side outputs
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            powered_reg <= 1'b0;
            converting_reg <= 1'b0;
            conv_done_reg <= 1'b0;
            step_total_reg <= 8'h00;
        end
        else
        begin
            powered_reg <= power_reg;
            converting_reg <= running;
            conv_done_reg <= cycle_done;
            step_total_reg <= manual_mode ? 8'h00 : step_total;
        end
    end

    assign link.ack = ack_reg;
    assign link.rdata = rdata_reg;
    assign link.irq_n = irq_n_reg;
    assign powered_o = powered_reg;
    assign converting_o = converting_reg;
    assign conv_done_o = conv_done_reg;
    assign step_total_o = step_total_reg;

endmodule
`default_nettype wire

// *** core/lapic_host.sv ***
// Purpose: Host controller end: APB registers that issue link commands to the light ADC device
// Assumes: APB signals synchronous to clock_i; one wait state on every access
// Notes: Control writes are cleaned and sequenced so power precedes enable by the settle time
`timescale 1ns/10ps
`default_nettype none
module lapic_host #(
    parameter int POWER_WAIT_CYCLES = lapic_pkg::POWER_WAIT_CYCLES
) (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    lapic_link_if.host link
);

    typedef enum logic [1:0] {
        LAPIC_ST_IDLE = 2'b00,
        LAPIC_ST_SEND = 2'b01,
        LAPIC_ST_WAIT = 2'b10
    } lapic_hstate_t;

    lapic_hstate_t state_reg;
    lapic_pkg::lapic_kind_t kind_reg;
    logic [4:0] addr_reg;
    logic [7:0] op_data_reg;
    logic [7:0] wdata_reg;
    logic req_reg;
    logic pend_reg;
    logic pwr_shadow_reg;
    logic [lapic_pkg::CNT_W-1:0] wait_reg;
    logic [7:0] rdata_reg;
    logic [lapic_pkg::IRQ_W-1:0] irq_stat_reg;
    logic [lapic_pkg::IRQ_W-1:0] irq_mask_reg;
    logic irq_reg;
    logic dev_irq_prev_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;

    // APB decode; the write takes effect at the edge that samples pready high
    wire access = psel_i & penable_i & ~pready_reg;
    wire apb_done = psel_i & penable_i & pready_reg;
    wire hit_cmd = (paddr_i == lapic_pkg::APB_CMD_OFS);
    wire hit_stat = (paddr_i == lapic_pkg::APB_STATUS_OFS);
    wire hit_istat = (paddr_i == lapic_pkg::APB_IRQ_STAT_OFS);
    wire hit_imask = (paddr_i == lapic_pkg::APB_IRQ_MASK_OFS);
    wire mapped = hit_cmd | hit_stat | hit_istat | hit_imask;
    wire busy = (state_reg != LAPIC_ST_IDLE);
    // The refusal decided in the access cycle also holds at completion
    wire cmd_wr = apb_done & pwrite_i & hit_cmd & ~pslverr_reg;
    wire cmd_refused = pwrite_i & hit_cmd & busy;

    // Command word decode and control write cleanup
    wire lapic_pkg::lapic_kind_t cmd_kind = lapic_pkg::lapic_kind_t'(pwdata_i[lapic_pkg::CMD_KIND_LSB +: 2]);
    wire [4:0] cmd_addr = pwdata_i[lapic_pkg::CMD_ADDR_LSB +: 5];
    wire [7:0] cmd_raw = pwdata_i[lapic_pkg::CMD_DATA_LSB +: 8];
    wire is_ctrl_wr = (cmd_kind == lapic_pkg::LAPIC_KIND_WRITE) & (cmd_addr == lapic_pkg::CTRL_ADDR);
    wire [7:0] ctrl_clean = cmd_raw & lapic_pkg::CTRL_WRITABLE_MASK;
    wire [7:0] ctrl_fixed = ctrl_clean | (ctrl_clean[lapic_pkg::CTRL_EN_BIT] ? lapic_pkg::CTRL_POWER_ONLY : 8'h00);
    wire [7:0] cmd_data = is_ctrl_wr ? ctrl_fixed : cmd_raw;
    wire wants_en = is_ctrl_wr & ctrl_fixed[lapic_pkg::CTRL_EN_BIT];
    wire need_pwr = wants_en & ~pwr_shadow_reg;
    wire need_wait = wants_en & pwr_shadow_reg & (wait_reg != '0);

    // Link completion
    wire link_done = (state_reg == LAPIC_ST_SEND) & link.ack;
    wire sent_ctrl = (kind_reg == lapic_pkg::LAPIC_KIND_WRITE) & (addr_reg == lapic_pkg::CTRL_ADDR);
    wire pwr_rise = link_done & sent_ctrl & wdata_reg[lapic_pkg::CTRL_POWER_BIT] & ~pwr_shadow_reg;
    wire dev_irq = ~link.irq_n;

    // Interrupt status: set wins over a write-one clear
    wire [lapic_pkg::IRQ_W-1:0] irq_evt = {dev_irq & ~dev_irq_prev_reg, link_done & ~pend_reg};
    wire [lapic_pkg::IRQ_W-1:0] irq_clr = (apb_done & pwrite_i & hit_istat) ? pwdata_i[lapic_pkg::IRQ_W-1:0] : '0;
    wire [lapic_pkg::IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_evt;

    // Read mux
    wire [31:0] stat_word = {14'h0000, (pwr_shadow_reg & (wait_reg == '0)), dev_irq, rdata_reg, 7'h00, busy};
    wire [31:0] cmd_word = {17'h00000, kind_reg, addr_reg, op_data_reg};
    wire [31:0] read_mux = hit_cmd ? cmd_word :
                           hit_stat ? stat_word :
                           hit_istat ? {30'h00000000, irq_stat_reg} :
                           hit_imask ? {30'h00000000, irq_mask_reg} : 32'h00000000;

    // APB slave
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
            dev_irq_prev_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= access;
            pslverr_reg <= access & (~mapped | cmd_refused);
            if (access && !pwrite_i)
            begin
                prdata_reg <= read_mux;
            end
            if (apb_done && pwrite_i && hit_imask)
            begin
                irq_mask_reg <= pwdata_i[lapic_pkg::IRQ_W-1:0];
            end
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
            dev_irq_prev_reg <= dev_irq;
        end
    end

    // Link sequencer
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_reg <= LAPIC_ST_IDLE;
            kind_reg <= lapic_pkg::LAPIC_KIND_WRITE;
            addr_reg <= 5'h00;
            op_data_reg <= 8'h00;
            wdata_reg <= 8'h00;
            req_reg <= 1'b0;
            pend_reg <= 1'b0;
            pwr_shadow_reg <= 1'b0;
            wait_reg <= '0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            if (pwr_rise)
            begin
                wait_reg <= lapic_pkg::CNT_W'(POWER_WAIT_CYCLES);
            end
            else if (wait_reg != '0)
            begin
                wait_reg <= wait_reg - lapic_pkg::CNT_W'(1);
            end
            case (state_reg)
                LAPIC_ST_IDLE:
                begin
                    if (cmd_wr)
                    begin
                        kind_reg <= cmd_kind;
                        addr_reg <= cmd_addr;
                        op_data_reg <= cmd_data;
                        if (need_pwr)
                        begin
                            // Power first, then enable after the settle time
                            wdata_reg <= lapic_pkg::CTRL_POWER_ONLY;
                            pend_reg <= 1'b1;
                            req_reg <= 1'b1;
                            state_reg <= LAPIC_ST_SEND;
                        end
                        else if (need_wait)
                        begin
                            state_reg <= LAPIC_ST_WAIT;
                        end
                        else
                        begin
                            wdata_reg <= cmd_data;
                            req_reg <= 1'b1;
                            state_reg <= LAPIC_ST_SEND;
                        end
                    end
                end
                LAPIC_ST_SEND:
                begin
                    if (link.ack)
                    begin
                        req_reg <= 1'b0;
                        if (kind_reg == lapic_pkg::LAPIC_KIND_READ)
                        begin
                            rdata_reg <= link.rdata;
                        end
                        if (sent_ctrl)
                        begin
                            pwr_shadow_reg <= wdata_reg[lapic_pkg::CTRL_POWER_BIT];
                        end
                        state_reg <= pend_reg ? LAPIC_ST_WAIT : LAPIC_ST_IDLE;
                    end
                end
                LAPIC_ST_WAIT:
                begin
                    if (wait_reg == '0)
                    begin
                        wdata_reg <= op_data_reg;
                        pend_reg <= 1'b0;
                        req_reg <= 1'b1;
                        state_reg <= LAPIC_ST_SEND;
                    end
                end
                default:
                begin
                    state_reg <= LAPIC_ST_IDLE;
                end
            endcase
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;
    assign link.req = req_reg;
    assign link.kind = kind_reg;
    assign link.addr = addr_reg;
    assign link.wdata = wdata_reg;

endmodule
`default_nettype wire

// *** testbench/lapic_chk.sv ***
// Purpose: Link checks between host and device ends
// Assumes: One clock, asynchronous active low reset
// Notes: Shadow copies track the last bytes written to the device
`timescale 1ns/10ps
`default_nettype none
module lapic_chk (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic req,
    input wire lapic_pkg::lapic_kind_t kind,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic irq_n
);
    logic [7:0] ctrl_reg;
    logic [7:0] tim_reg;
    wire logic take = req && !ack;
    wire logic wr_take = take && kind == lapic_pkg::LAPIC_KIND_WRITE;
    wire logic rd_ack = ack && kind == lapic_pkg::LAPIC_KIND_READ;
    wire logic ctrl_sel = addr == lapic_pkg::CTRL_ADDR;
    wire logic tim_sel = addr == lapic_pkg::TIMING_ADDR;
    wire logic clr_take = take && kind == lapic_pkg::LAPIC_KIND_SPECIAL && addr == lapic_pkg::FN_IRQ_CLEAR;
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_reg <= 8'h00;
            tim_reg <= 8'h00;
        end
        else
        begin
            if (wr_take && ctrl_sel)
                ctrl_reg <= wdata;
            if (wr_take && tim_sel)
                tim_reg <= wdata;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    chk_ack_follows: assert property (take |=> ack) else $error("no ack after request");
    chk_ack_pulse: assert property (ack |=> !ack) else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack |-> req) else $error("ack without request");
    chk_req_held: assert property (take |=> req && $stable(addr) && $stable(wdata)) else $error("request changed");
    chk_ctrl_clean: assert property (wr_take && ctrl_sel |-> wdata[7:2] == 6'h00) else $error("reserved bits");
    chk_en_power: assert property (wr_take && ctrl_sel && wdata[1] |-> wdata[0]) else $error("enable without power");
    chk_ctrl_read: assert property (rd_ack && ctrl_sel |-> {rdata[7:6], rdata[3:0]} == {4'h0, ctrl_reg[1:0]})
        else $error("control readback");
    chk_irq_bit: assert property (rd_ack && ctrl_sel |-> rdata[5] == !$past(irq_n)) else $error("irq bit");
    chk_tim_read: assert property (rd_ack && tim_sel |-> rdata == tim_reg) else $error("timing readback");
    chk_irq_clear: assert property (clr_take |=> irq_n) else $error("irq not cleared");
    cover property (clr_take);
    cover property ($fell(irq_n));
    cover property (rd_ack && ctrl_sel);
endmodule
`default_nettype wire

// *** testbench/lapic_test.sv ***
// Purpose: Self-checking bench for both link ends
// Assumes: Short step and settle counts
// Notes: Device commands go through the host APB registers
`timescale 1ns/10ps
`default_nettype none
module lapic_test;
    localparam int STEP = 4;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic powered;
    logic converting;
    logic conv_done;
    logic [7:0] step_total;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int tests_run = 0;
    lapic_link_if lapic_link_if_inst ();
    lapic_dev #(.STEP_CYCLES(STEP)) lapic_dev_inst (.clock_i(clock_i), .nrst_i(nrst_i), .link(lapic_link_if_inst.dev),
        .powered_o(powered), .converting_o(converting), .conv_done_o(conv_done), .step_total_o(step_total));
    lapic_host #(.POWER_WAIT_CYCLES(8)) lapic_host_inst (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .link(lapic_link_if_inst.host));
    lapic_chk lapic_chk_inst (.clock_i(clock_i), .nrst_i(nrst_i), .req(lapic_link_if_inst.req),
        .kind(lapic_link_if_inst.kind), .addr(lapic_link_if_inst.addr), .wdata(lapic_link_if_inst.wdata),
        .ack(lapic_link_if_inst.ack), .rdata(lapic_link_if_inst.rdata), .irq_n(lapic_link_if_inst.irq_n));
    initial
    begin
        forever #25 clock_i = ~clock_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic guard(input int n);
        if (n > 2500)
        begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            summarize();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do
        begin
            @(negedge clock_i);
            n++;
            guard(n * 50);
        end
        while (pready !== 1'b1);
        @(posedge clock_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, lapic_pkg::APB_STATUS_OFS, 32'h0);
            n++;
            guard(n * 40);
        end
        while (rd[lapic_pkg::STAT_BUSY_BIT] !== 1'b0);
    endtask
    // A command is only issued once the host is idle, so it is never refused
    task automatic cmd(input logic [1:0] k, input logic [4:0] a, input logic [7:0] d);
        wait_idle();
        apb(1'b1, lapic_pkg::APB_CMD_OFS, {17'h0, k, a, d});
        check(er, 1'b0);
        wait_idle();
    endtask
    task automatic period(input int exp);
        int n;
        n = 0;
        while (conv_done !== 1'b1)
        begin
            @(negedge clock_i);
            n++;
            guard(n);
        end
        n = 0;
        do
        begin
            @(negedge clock_i);
            n++;
            guard(n);
        end
        while (conv_done !== 1'b1);
        check(n, exp);
    endtask
    task automatic t_reset();
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        cmd(lapic_pkg::LAPIC_KIND_READ, lapic_pkg::TIMING_ADDR, 8'h00);
        check(rd[15:8], 8'h00);
        cmd(lapic_pkg::LAPIC_KIND_READ, lapic_pkg::CTRL_ADDR, 8'h00);
        check(rd[15:8], 8'h00);
        apb(1'b0, 12'h010, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
    endtask
    task automatic t_power();
        cmd(lapic_pkg::LAPIC_KIND_WRITE, lapic_pkg::TIMING_ADDR, 8'h00);
        // Enable asked with power off: power goes first, enable is held back
        apb(1'b1, lapic_pkg::APB_CMD_OFS, {19'h0, lapic_pkg::CTRL_ADDR, 8'hfe});
        apb(1'b1, lapic_pkg::APB_CMD_OFS, 32'h0);
        check(er, 1'b1);
        @(negedge clock_i);
        check(powered, 1'b1);
        cmd(lapic_pkg::LAPIC_KIND_READ, lapic_pkg::CTRL_ADDR, 8'h00);
        check(rd[15:8], 8'h03);
    endtask
    task automatic t_timed();
        logic [7:0] tv [3] = '{8'hff, 8'hfe, 8'h01};
        for (int i = 0; i < 3; i++)
        begin
            cmd(lapic_pkg::LAPIC_KIND_WRITE, lapic_pkg::TIMING_ADDR, tv[i]);
            check(step_total, 256 - tv[i]);
            period((256 - tv[i]) * STEP);
        end
        cmd(lapic_pkg::LAPIC_KIND_READ, lapic_pkg::CTRL_ADDR, 8'h00);
        check(rd[15:8], 8'h33);
    endtask
    task automatic t_irq();
        // The interrupt output follows status and mask one edge late
        apb(1'b1, lapic_pkg::APB_IRQ_MASK_OFS, 32'h3);
        repeat (2) @(negedge clock_i);
        check(irq, 1'b1);
        apb(1'b1, lapic_pkg::APB_IRQ_STAT_OFS, 32'h3);
        repeat (2) @(negedge clock_i);
        check(irq, 1'b0);
        apb(1'b1, lapic_pkg::APB_IRQ_MASK_OFS, 32'h0);
        cmd(lapic_pkg::LAPIC_KIND_WRITE, lapic_pkg::TIMING_ADDR, 8'h00);
        apb(1'b0, lapic_pkg::APB_IRQ_STAT_OFS, 32'h0);
        check(rd[1:0], 2'b01);
        @(negedge clock_i);
        check(irq, 1'b0);
    endtask
    task automatic t_manual();
        cmd(lapic_pkg::LAPIC_KIND_SPECIAL, lapic_pkg::FN_IRQ_CLEAR, 8'h00);
        check(lapic_link_if_inst.irq_n, 1'b1);
        cmd(lapic_pkg::LAPIC_KIND_SPECIAL, lapic_pkg::FN_START, 8'h00);
        repeat (3 * STEP) @(negedge clock_i);
        check({converting, lapic_link_if_inst.irq_n}, 2'b11);
        cmd(lapic_pkg::LAPIC_KIND_SPECIAL, lapic_pkg::FN_STOP, 8'h00);
        check({converting, lapic_link_if_inst.irq_n}, 2'b00);
        cmd(lapic_pkg::LAPIC_KIND_WRITE, lapic_pkg::CTRL_ADDR, 8'h00);
        check({powered, converting}, 2'b00);
        cmd(lapic_pkg::LAPIC_KIND_READ, lapic_pkg::CTRL_ADDR, 8'h00);
        check(rd[15:8], 8'h20);
    endtask
    initial
    begin
        t_reset();
        t_power();
        t_timed();
        t_irq();
        t_manual();
        // A non-zero timing value shows whether the mid-run reset clears it
        cmd(lapic_pkg::LAPIC_KIND_WRITE, lapic_pkg::TIMING_ADDR, 8'hfe);
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
